// File: rilg_top.v
// Design decisions made here: the address map and the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "rilg_defs.vh"
// ----------------------------------------
// reference input power-down and loss gating
// ----------------------------------------
module rilg_top
(
    input wire clk_sys,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output wire [31:0] prdata,
    input wire [3:0] ref_edge,
    input wire first_pll_unlock,
    output wire [3:0] ref_input_disable,
    output reg first_pll_unlock_flag_n,
    output reg first_pll_unlock_pin_n,
    output reg lock,
    output wire irq
);
    wire [31:0] ctrl_reg;
    wire [3:0] irq_reg;
    wire [3:0] mask_reg;
    wire [3:0] signal_absent;
    wire [3:0] loss_event;
    wire [1:0] sel;
    wire ref_loss_mask;
    wire sel_lost;
    wire unlock_next;
    assign ref_input_disable = ctrl_reg[`RILG_CTRL_DIS_LSB +: 4];
    assign sel = ctrl_reg[`RILG_CTRL_SEL_LSB +: 2];
    assign ref_loss_mask = ctrl_reg[`RILG_CTRL_LOSSMASK_BIT];
    assign sel_lost = signal_absent[sel];
    // mask blocks inactivity from indicators and lock pin
    assign unlock_next = first_pll_unlock || (sel_lost && !ref_loss_mask);
    assign irq = |(irq_reg & mask_reg);
    rilg_apb u_apb
    (
        .clk_sys(clk_sys),
        .reset(reset),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .stat_in({27'h000_0000, !lock, signal_absent}),
        .irq_set(loss_event),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .ctrl_reg(ctrl_reg),
        .irq_reg(irq_reg),
        .mask_reg(mask_reg)
    );
    genvar i;
    generate
        for (i = 0; i < 4; i = i + 1)
        begin : g_mon
            rilg_monitor u_mon
            (
                .clk_sys(clk_sys),
                .reset(reset),
                .enable(!ref_input_disable[i]),
                .ref_edge(ref_edge[i]),
                .revalidation_count_sel(ctrl_reg[`RILG_CTRL_CNT_LSB +: 2]),
                .signal_absent(signal_absent[i]),
                .loss_event(loss_event[i])
            );
        end
    endgenerate
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            first_pll_unlock_flag_n <= 1'b1;
            first_pll_unlock_pin_n <= 1'b1;
            lock <= 1'b0;
        end
        else
        begin
            first_pll_unlock_flag_n <= !unlock_next;
            first_pll_unlock_pin_n <= !unlock_next;
            lock <= !unlock_next;
        end
    end
endmodule
`default_nettype wire

// File: rilg_defs.vh
`ifndef RILG_DEFS_VH
`define RILG_DEFS_VH
`define RILG_CTRL_ADDR 12'h000
`define RILG_STAT_ADDR 12'h004
`define RILG_IRQ_ADDR 12'h008
`define RILG_MASK_ADDR 12'h00C
`define RILG_CTRL_DIS_LSB 0
`define RILG_CTRL_SEL_LSB 4
`define RILG_CTRL_CNT_LSB 8
`define RILG_CTRL_LOSSMASK_BIT 12
`define RILG_CTRL_RESET 32'h0000_0200
`define RILG_REVAL_0 10'h002
`define RILG_REVAL_1 10'h010
`define RILG_REVAL_2 10'h020
`define RILG_REVAL_3 10'h040
`define RILG_TIMEOUT_NS 1000
`define RILG_CLK_NS 50
// 1000 ns of silence at a 50 ns clock
`define RILG_TIMEOUT_CYC 10'h014
`endif

// File: rilg_monitor.v
`timescale 1ns/100ps
`default_nettype none
`include "rilg_defs.vh"
// ----------------------------------------
// activity monitor for one reference input
// ----------------------------------------
module rilg_monitor
(
    input wire clk_sys,
    input wire reset,
    input wire enable,
    input wire ref_edge,
    input wire [1:0] revalidation_count_sel,
    output reg signal_absent,
    output wire loss_event
);
    localparam [9:0] TIMEOUT = `RILG_TIMEOUT_CYC;
    reg [9:0] gap_reg;
    reg [9:0] reval_reg;
    wire miss;
    function [9:0] reval_load;
        input [1:0] sel;
        begin
            case (sel)
                2'b00: reval_load = `RILG_REVAL_0;
                2'b01: reval_load = `RILG_REVAL_1;
                2'b10: reval_load = `RILG_REVAL_2;
                default: reval_load = `RILG_REVAL_3;
            endcase
        end
    endfunction
    assign miss = enable && !ref_edge && (gap_reg == TIMEOUT - 10'h001);
    assign loss_event = miss && !signal_absent;
    always @(posedge clk_sys)
    begin
        if (reset || !enable)
        begin
            gap_reg <= 10'h000;
            reval_reg <= 10'h000;
            signal_absent <= 1'b0;
        end
        else
        begin
            if (ref_edge || miss)
                gap_reg <= 10'h000;
            else
                gap_reg <= gap_reg + 10'h001;
            if (miss)
            begin
                signal_absent <= 1'b1;
                reval_reg <= reval_load(revalidation_count_sel);
            end
            else if (signal_absent && ref_edge)
            begin
                if (reval_reg <= 10'h001)
                    signal_absent <= 1'b0;
                else
                    reval_reg <= reval_reg - 10'h001;
            end
        end
    end
endmodule
`default_nettype wire

// File: rilg_apb.v
`timescale 1ns/100ps
`default_nettype none
`include "rilg_defs.vh"
// ----------------------------------------
// apb slave, zero wait states
// ----------------------------------------
module rilg_apb
(
    input wire clk_sys,
    input wire reset,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    input wire [31:0] stat_in,
    input wire [3:0] irq_set,
    output wire pready,
    output wire pslverr,
    output reg [31:0] prdata,
    output reg [31:0] ctrl_reg,
    output reg [3:0] irq_reg,
    output reg [3:0] mask_reg
);
    wire wr;
    wire [3:0] clr;
    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr = psel && penable && pwrite;
    assign clr = (wr && paddr == `RILG_IRQ_ADDR) ? pwdata[3:0] : 4'h0;
    always @(posedge clk_sys)
    begin
        if (reset)
        begin
            ctrl_reg <= `RILG_CTRL_RESET;
            irq_reg <= 4'h0;
            mask_reg <= 4'h0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            irq_reg <= (irq_reg & ~clr) | irq_set;
            if (wr && paddr == `RILG_CTRL_ADDR)
                ctrl_reg <= pwdata & 32'h0000_133f;
            if (wr && paddr == `RILG_MASK_ADDR)
                mask_reg <= pwdata[3:0];
            if (psel && !penable && !pwrite)
            begin
                case (paddr)
                    `RILG_CTRL_ADDR: prdata <= ctrl_reg;
                    `RILG_STAT_ADDR: prdata <= stat_in;
                    `RILG_IRQ_ADDR: prdata <= {28'h000_0000, irq_reg};
                    `RILG_MASK_ADDR: prdata <= {28'h000_0000, mask_reg};
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

// File: rilg_assertions.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// port checks
// ----
module rilg_checker (
    input wire logic clk_sys,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic first_pll_unlock,
    input wire logic [3:0] ref_input_disable,
    input wire logic first_pll_unlock_flag_n,
    input wire logic first_pll_unlock_pin_n,
    input wire logic lock
);
default clocking @(posedge clk_sys); endclocking
default disable iff (reset);
a_unlock_flag: assert property (first_pll_unlock |=> !first_pll_unlock_flag_n)
    else $error("flag missed unlock");
a_unlock_pin: assert property (first_pll_unlock |=> !first_pll_unlock_pin_n)
    else $error("pin missed unlock");
a_flags_agree: assert property (first_pll_unlock_flag_n == first_pll_unlock_pin_n)
    else $error("indicators differ");
a_lock_drop: assert property (first_pll_unlock |=> !lock)
    else $error("lock held on unlock");
a_lock_vs_flag: assert property (lock |-> first_pll_unlock_flag_n)
    else $error("lock with unlock flag");
a_disable_hold: assert property (!(psel && penable && pwrite) |=> $stable(ref_input_disable))
    else $error("disable moved");
a_bus_ready: assert property (pready && !pslverr)
    else $error("bus answer wrong");
endmodule
bind rilg_top rilg_checker chk_u (.clk_sys, .reset, .psel, .penable, .pwrite, .pready,
    .pslverr, .first_pll_unlock, .ref_input_disable, .first_pll_unlock_flag_n,
    .first_pll_unlock_pin_n, .lock);
`default_nettype wire

// File: ref_input_loss_gating_bench.sv
`timescale 1ns/100ps
`default_nettype none
// ----
// bench
// ----
module ref_input_loss_gating_bench;
logic clk_sys = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, first_pll_unlock = 0;
logic [11:0] paddr = 0;
logic [31:0] pwdata = 0, dis, rd_exp[$];
logic [3:0] ref_edge = 0, ref_run = 4'hf;
wire [31:0] prdata;
wire [3:0] ref_input_disable;
wire pready, pslverr, first_pll_unlock_flag_n, first_pll_unlock_pin_n, lock, irq;
int num_errors = 0, num_checks = 0, seed = 32'hfa39_0d48;
rilg_top dut_u (.clk_sys, .reset, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .pslverr, .prdata, .ref_edge, .first_pll_unlock, .ref_input_disable,
    .first_pll_unlock_flag_n, .first_pll_unlock_pin_n, .lock, .irq);
always #25 clk_sys = ~clk_sys;
always @(posedge clk_sys) ref_edge <= ref_run;
task check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
        num_errors++;
        $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
endtask
task settle(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
endtask
task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    @(posedge clk_sys);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) rd_exp.push_back(e);
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(negedge clk_sys);
endtask
always @(posedge clk_sys)
    if (psel && penable && !pwrite && pready) check(prdata, rd_exp.pop_front());
task wrap_up;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask
initial
begin
    #100_000;
    num_errors++;
    wrap_up;
end
initial
begin
    repeat (16) @(posedge clk_sys);
    reset <= 0;
    settle(1);
    check(ref_input_disable, 0);
    check(first_pll_unlock_flag_n, 1);
    apb(0, 12'h000, 0, 32'h0000_0200);
    apb(1, 12'h00c, 32'h0000_000f, 0);
    dis = $random(seed) & 32'h0000_000f;
    apb(1, 12'h000, dis, 0);
    apb(0, 12'h000, 0, dis);
    check(ref_input_disable, dis);
    apb(1, 12'h000, 0, 0);
    @(posedge clk_sys) first_pll_unlock <= 1;
    settle(3);
    check(first_pll_unlock_pin_n, 0);
    check(lock, 0);
    @(posedge clk_sys) first_pll_unlock <= 0;
    ref_run <= 4'he;
    settle(30);
    check(first_pll_unlock_flag_n, 0);
    check(first_pll_unlock_pin_n, 0);
    check(lock, 0);
    check(irq, 1);
    apb(1, 12'h000, 32'h0000_1000, 0);
    settle(3);
    check(first_pll_unlock_flag_n, 1);
    check(lock, 1);
    @(posedge clk_sys) ref_run <= 4'hf;
    settle(10);
    apb(0, 12'h004, 0, 0);
    apb(1, 12'h008, 32'h0000_000f, 0);
    check(irq, 0);
    apb(1, 12'h000, 32'h0000_0002, 0);
    @(posedge clk_sys) ref_run <= 4'hd;
    settle(30);
    check(irq, 0);
    apb(0, 12'h004, 0, 0);
    apb(0, 12'h100, 0, 0);
    // select input 2, re-validation count 16
    apb(1, 12'h000, 32'h0000_0120, 0);
    @(posedge clk_sys) ref_run <= 4'hb;
    settle(30);
    check(first_pll_unlock_pin_n, 0);
    @(posedge clk_sys) ref_run <= 4'hf;
    settle(10);
    check(first_pll_unlock_flag_n, 0);
    settle(10);
    check(first_pll_unlock_flag_n, 1);
    wrap_up;
end
endmodule
`default_nettype wire
